// ### inc/idb_pkg.sv
// package: constants for the isa dma to local bus bridge
package idb_pkg;
  // ==========================================================
  // sizes
  localparam int unsigned NSLOT = 3;
  localparam int unsigned SYNC_W = 48;
  localparam int unsigned SA_W = 17;
  localparam int unsigned LA_W = 7;
  localparam int unsigned SD_W = 16;
  localparam int unsigned DAT_W = 32;
  localparam int unsigned ADR_W = 30;
  localparam int unsigned BE_W = 4;
  // ==========================================================
  // field positions inside the synchronised isa bundle
  localparam int unsigned F_SD = 0;
  localparam int unsigned F_SA = 16;
  localparam int unsigned F_LA = 33;
  localparam int unsigned F_SBHE = 40;
  localparam int unsigned F_MASTER = 41;
  localparam int unsigned F_REFRESH = 42;
  localparam int unsigned F_AEN = 43;
  localparam int unsigned F_IOW = 44;
  localparam int unsigned F_IOR = 45;
  localparam int unsigned F_MEMW = 46;
  localparam int unsigned F_MEMR = 47;
  // ==========================================================
  // reset values
  localparam logic [47:0] SYNC_RST = 48'hF400_0000_0000;
  localparam logic [2:0] GNT_RST = 3'h7;
  localparam logic [29:0] ADR_RST = 30'h0000_0000;
  localparam logic [15:0] SD_RST = 16'h0000;
  localparam logic [31:0] DAT_RST = 32'h0000_0000;
  localparam logic [3:0] BE_RST = 4'hF;
  // ==========================================================
  // timing: targets need 20 ns to decode before the claim is sampled
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned T_CLAIM_NS = 20;
  localparam int unsigned CLAIM_CYC = (T_CLAIM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] CLAIM_LAST = 2'(CLAIM_CYC - 1);
  // ==========================================================
  // bridge sequencer
  typedef enum logic [2:0] {
    IDB_IDLE,
    IDB_ADS,
    IDB_CLAIM,
    IDB_WAIT,
    IDB_RET,
    IDB_END
  } idb_state_t;
endpackage

// ### rtl/idb_bridge.sv
// module: carries isa dma and isa master cycles onto the local slot bus
// ==========================================================
// Notes on behaviour
// - m/io pin high for memory strobes
// - w/r pin high for memory/io writes
// - aen without refresh drives address out
// - refresh cycles ignored entirely
// - iochrdy pulled low once target claims
// - iochrdy released on target ready
// - sa, la, sbhe forwarded to address
// - memory write: sd onto local data
// - memory read: local data onto sd
// - memcs16 asserted for claimed transfers
// - echo claimed isa transfers onto local bus
// - drive address group while isa side owns
// - local master owns: address pins inputs
// - claim, request, grant one per slot
// - wide transfer: upper lanes on address pins
// - sample claim, ignore on local hit
module idb_bridge (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // isa command and status pins
  input wire logic i_memr_n,
  input wire logic i_memw_n,
  input wire logic i_ior_n,
  input wire logic i_iow_n,
  input wire logic i_aen,
  input wire logic i_refresh_n,
  input wire logic i_isa_master,
  // isa address and data
  input wire logic [16:0] i_sa,
  input wire logic [23:17] i_la,
  input wire logic i_sbhe_n,
  input wire logic [15:0] i_sd,
  output logic [15:0] o_sd,
  output logic o_sd_oe,
  // isa open-drain answers, pin low while oe high
  output logic o_iochrdy,
  output logic o_iochrdy_oe,
  output logic o_memcs16_n,
  output logic o_memcs16_n_oe,
  // local address group, two-way
  input wire logic [29:0] i_adr,
  output logic [29:0] o_adr,
  output logic o_adr_oe,
  output logic o_address_strobe_n,
  output logic [3:0] o_byte_lane_enables_n,
  output logic o_mem_io,
  output logic o_write_read,
  output logic o_data_code,
  output logic o_wide_transfer_request_n,
  // local data bus
  input wire logic [31:0] i_local_data_bus,
  output logic [31:0] o_local_data_bus,
  output logic o_local_data_bus_oe,
  // target answers; ready return driven on bridge and local master cycles, the rest only toward a local master
  input wire logic i_target_ready_n,
  input wire logic i_burst_ready_n,
  input wire logic i_size16_request_n,
  input wire logic i_wide_transfer_ack_n,
  output logic o_burst_ready_n,
  output logic o_size16_request_n,
  output logic o_wide_transfer_ack_n,
  output logic o_answer_oe,
  output logic o_ready_return_n,
  // per slot claim and arbitration
  input wire logic [2:0] i_target_claim_n,
  input wire logic [2:0] i_master_request_n,
  output logic [2:0] o_master_grant_n,
  // system side
  input wire logic i_local_hit,
  input wire logic i_wide_enable
);
  // ==========================================================
  // helpers
  // byte enables for a 16-bit isa access inside a 32-bit word
  function automatic logic [3:0] isa_be_n(input logic a1, input logic a0, input logic bhe_n);
    isa_be_n = a1 ? {bhe_n, a0, 2'b11} : {2'b11, bhe_n, a0};
  endfunction
  // pick the 16-bit half of a word that the isa address selects
  function automatic logic [15:0] half_sel(input logic a1, input logic [31:0] w);
    half_sel = a1 ? w[31:16] : w[15:0];
  endfunction

  // ==========================================================
  // input synchronisers
  logic [47:0] sync1_r;
  logic [47:0] sync2_r;
  // async isa pins cross two flops before anything looks at them
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      sync1_r <= idb_pkg::SYNC_RST;
      sync2_r <= idb_pkg::SYNC_RST;
    end
    else
    begin
      sync1_r <= {i_memr_n, i_memw_n, i_ior_n, i_iow_n, i_aen, i_refresh_n,
                  i_isa_master, i_sbhe_n, i_la, i_sa, i_sd};
      sync2_r <= sync1_r;
    end
  end

  // ==========================================================
  // decoded isa status
  wire memr_act = !sync2_r[idb_pkg::F_MEMR];
  wire memw_act = !sync2_r[idb_pkg::F_MEMW];
  wire ior_act = !sync2_r[idb_pkg::F_IOR];
  wire iow_act = !sync2_r[idb_pkg::F_IOW];
  wire cmd_act = memr_act | memw_act | ior_act | iow_act;
  wire refresh_act = !sync2_r[idb_pkg::F_REFRESH];
  wire isa_cycle = sync2_r[idb_pkg::F_AEN] | sync2_r[idb_pkg::F_MASTER];
  wire [16:0] sa_s = sync2_r[idb_pkg::F_SA +: 17];
  wire [6:0] la_s = sync2_r[idb_pkg::F_LA +: 7];
  wire [15:0] sd_s = sync2_r[idb_pkg::F_SD +: 16];
  wire sbhe_s = sync2_r[idb_pkg::F_SBHE];
  wire claim_any = (i_target_claim_n != 3'h7);
  wire [2:0] req = ~i_master_request_n;

  // ==========================================================
  // arbitration state
  logic [2:0] gnt_r;
  logic [2:0] gnt_nxt;
  wire lbm_own = (gnt_r != 3'h0);
  // lowest slot wins; a grant holds until its request drops
  assign gnt_nxt = lbm_own ? (gnt_r & req) : (req & (~req + 3'h1));

  // ==========================================================
  // sequencer
  idb_pkg::idb_state_t state_r;
  idb_pkg::idb_state_t state_nxt;
  logic [1:0] cnt_r;
  logic claimed_r;
  logic mio_r;
  logic wr_r;
  logic [29:0] adr_r;
  logic [3:0] be_r;
  logic [31:0] wdat_r;
  logic [15:0] rdat_r;
  logic ready_return_n_r;
  logic wide_r;
  logic half_r;
  // refresh never starts a cycle, and a granted local master blocks one
  wire go = isa_cycle & cmd_act & !refresh_act & !lbm_own;
  wire claim_ok = claim_any & !i_local_hit;
  wire ready_seen = !i_target_ready_n;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      idb_pkg::IDB_IDLE:
        if (go)
          state_nxt = idb_pkg::IDB_ADS;
      idb_pkg::IDB_ADS:
        state_nxt = idb_pkg::IDB_CLAIM;
      idb_pkg::IDB_CLAIM:
        if (cnt_r == idb_pkg::CLAIM_LAST)
          state_nxt = claim_ok ? idb_pkg::IDB_WAIT : idb_pkg::IDB_END;
      idb_pkg::IDB_WAIT:
        if (ready_seen)
          state_nxt = idb_pkg::IDB_RET;
      idb_pkg::IDB_RET:
        state_nxt = idb_pkg::IDB_END;
      idb_pkg::IDB_END:
        if (!cmd_act)
          state_nxt = idb_pkg::IDB_IDLE;
    endcase
  end

  // state, counter, grant
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      state_r <= idb_pkg::IDB_IDLE;
      cnt_r <= 2'h0;
      gnt_r <= 3'h0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= (state_r == idb_pkg::IDB_CLAIM) ? cnt_r + 2'h1 : 2'h0;
      // no grant on the edge that takes an isa cycle, or both would drive the bus
      gnt_r <= (state_r == idb_pkg::IDB_IDLE && !go) ? gnt_nxt : 3'h0;
    end
  end

  // cycle snapshot taken as the local cycle starts
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      mio_r <= 1'b0;
      wr_r <= 1'b0;
      adr_r <= idb_pkg::ADR_RST;
      be_r <= idb_pkg::BE_RST;
      wdat_r <= idb_pkg::DAT_RST;
      wide_r <= 1'b0;
      half_r <= 1'b0;
    end
    else if (state_r == idb_pkg::IDB_IDLE && go)
    begin
      mio_r <= memr_act | memw_act;
      wr_r <= memw_act | iow_act;
      adr_r <= {8'h00, la_s, sa_s[16:2]};
      be_r <= isa_be_n(sa_s[1], sa_s[0], sbhe_s);
      wdat_r <= sa_s[1] ? {sd_s, 16'h0000} : {16'h0000, sd_s};
      wide_r <= i_wide_enable;
      half_r <= sa_s[1]; // word half for the read return
    end
  end

  // claim flag, read capture and ready return
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      claimed_r <= 1'b0;
      rdat_r <= idb_pkg::SD_RST;
      ready_return_n_r <= 1'b1;
    end
    else
    begin
      if (state_r == idb_pkg::IDB_CLAIM && cnt_r == idb_pkg::CLAIM_LAST)
        claimed_r <= claim_ok;
      else if (state_r == idb_pkg::IDB_IDLE)
        claimed_r <= 1'b0;
      if (state_r == idb_pkg::IDB_WAIT && ready_seen)
        rdat_r <= half_sel(half_r, i_local_data_bus);
      // resynchronised return, one clock after target ready
      ready_return_n_r <= !((state_r == idb_pkg::IDB_WAIT || lbm_own) && ready_seen);
    end
  end

  // ==========================================================
  // local bus drive
  // the bridge owns the slot bus from strobe until the return
  wire own = (state_r == idb_pkg::IDB_ADS) || (state_r == idb_pkg::IDB_CLAIM) ||
             (state_r == idb_pkg::IDB_WAIT) || (state_r == idb_pkg::IDB_RET);
  // 64-bit data phase: upper lanes ride on the address and type pins
  wire wide_data = wide_r && !i_wide_transfer_ack_n && (state_r == idb_pkg::IDB_WAIT);
  assign o_adr_oe = own & !lbm_own;
  assign o_adr = wide_data ? idb_pkg::ADR_RST : adr_r;
  assign o_address_strobe_n = !(state_r == idb_pkg::IDB_ADS);
  assign o_byte_lane_enables_n = wide_data ? idb_pkg::BE_RST : be_r;
  assign o_mem_io = wide_data ? 1'b0 : mio_r;
  assign o_write_read = wide_data ? 1'b0 : wr_r;
  assign o_data_code = 1'b1;
  assign o_wide_transfer_request_n = !(own && wide_r);
  assign o_local_data_bus = wdat_r;
  assign o_local_data_bus_oe = own && wr_r && (state_r != idb_pkg::IDB_ADS);
  assign o_ready_return_n = ready_return_n_r;
  assign o_master_grant_n = ~gnt_r;
  // toward a local master; only when no slot target answers, so no contention
  assign o_answer_oe = lbm_own & !claim_any;
  assign o_burst_ready_n = 1'b1;
  assign o_size16_request_n = 1'b1;
  assign o_wide_transfer_ack_n = 1'b1;

  // ==========================================================
  // isa side drive
  assign o_iochrdy = 1'b0;
  assign o_iochrdy_oe = (state_r == idb_pkg::IDB_WAIT);
  assign o_memcs16_n = 1'b0;
  assign o_memcs16_n_oe = claimed_r && !(state_r == idb_pkg::IDB_IDLE);
  assign o_sd = rdat_r;
  // sd is driven only for a claimed memory read once data is caught
  assign o_sd_oe = claimed_r && mio_r && !wr_r &&
                   ((state_r == idb_pkg::IDB_RET) || (state_r == idb_pkg::IDB_END)) && memr_act;

  // ==========================================================
  // checks
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_nrst);

  property p_mio;
    (state_r == idb_pkg::IDB_IDLE && go) |=> (o_mem_io == $past(memr_act | memw_act));
  endproperty
  a_mio: assert property (p_mio) else $error("m/io does not follow strobe");

  property p_wr;
    (state_r == idb_pkg::IDB_IDLE && go) |=> (o_write_read == $past(memw_act | iow_act));
  endproperty
  a_wr: assert property (p_wr) else $error("w/r does not follow strobe");

  property p_refresh;
    refresh_act && (state_r == idb_pkg::IDB_IDLE) |=> o_address_strobe_n && !o_adr_oe;
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh cycle reached local bus");

  property p_claim_wait;
    (state_r == idb_pkg::IDB_CLAIM && cnt_r == idb_pkg::CLAIM_LAST && claim_ok) |=> o_iochrdy_oe;
  endproperty
  a_claim_wait: assert property (p_claim_wait) else $error("iochrdy not pulled after claim");

  property p_release;
    o_iochrdy_oe && ready_seen |=> !o_iochrdy_oe && !o_ready_return_n;
  endproperty
  a_release: assert property (p_release) else $error("iochrdy held past target ready");

  property p_cs16;
    o_iochrdy_oe |-> o_memcs16_n_oe;
  endproperty
  a_cs16: assert property (p_cs16) else $error("memcs16 missing on claimed cycle");

  property p_ads;
    go && (state_r == idb_pkg::IDB_IDLE) |=> !o_address_strobe_n ##1 o_address_strobe_n [*2];
  endproperty
  a_ads: assert property (p_ads) else $error("strobe not one clock");

  property p_own;
    lbm_own |-> !o_adr_oe && o_address_strobe_n;
  endproperty
  a_own: assert property (p_own) else $error("address driven under local master");

  property p_grant;
    $onehot0(~o_master_grant_n);
  endproperty
  a_grant: assert property (p_grant) else $error("more than one grant");
endmodule

// ### verif/idb_tgt_model.sv
// local target model standing on the slot bus beside the bridge
module idb_tgt_model #(
  parameter logic [3:0] HIT_NIB = 4'hC,
  parameter logic [31:0] RD = 32'hA5C3_5AF1
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // address group seen from the bridge
  input wire logic [29:0] i_adr,
  input wire logic i_adr_oe,
  input wire logic i_address_strobe_n,
  input wire logic i_write_read,
  input wire logic i_ready_return_n,
  input wire logic [3:0] i_wait,
  // data bus drive of the bridge
  input wire logic [31:0] i_bridge_data,
  input wire logic i_bridge_data_oe,
  // target answers
  output logic [2:0] o_target_claim_n,
  output logic o_target_ready_n,
  output logic [31:0] o_data_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy_r;
  logic hold_r;
  logic rd_r;
  logic [3:0] cnt_r;
  logic claim;
  // ==========================================================
  // decode: async, slot 0 only; empty slots stay pulled high
  assign claim = i_adr_oe && (i_adr[21:18] == HIT_NIB);
  assign o_target_claim_n = {2'h3, !claim};
  // released bus shows the inverse so stale data never matches
  assign o_data_level = i_bridge_data_oe ? i_bridge_data : (hold_r ? RD : ~RD);
  // one ready pulse per strobe, after i_wait cycles (slow or prompt)
  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      busy_r <= 1'h0;
      hold_r <= 1'h0;
      rd_r <= 1'h0;
      cnt_r <= 4'h0;
      o_target_ready_n <= 1'h1;
    end
    else
    begin
      if (!busy_r && !i_address_strobe_n && claim)
      begin
        busy_r <= 1'h1;
        cnt_r <= i_wait;
        rd_r <= !i_write_read;
      end
      else if (busy_r && !o_target_ready_n)
      begin
        o_target_ready_n <= 1'h1;
        busy_r <= 1'h0;
      end
      else if (busy_r && cnt_r != 4'h0)
        cnt_r <= cnt_r - 4'h1;
      else if (busy_r)
      begin
        o_target_ready_n <= 1'h0;
        hold_r <= rd_r;
      end
      if (hold_r && !i_ready_return_n)
        hold_r <= 1'h0;
    end
  end
endmodule

// ### verif/test_isa_dma_local_bus_bridge.sv
// self-checking bench for the isa dma to local bus bridge
module test_isa_dma_local_bus_bridge;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk, i_nrst, i_aen, i_refresh_n, i_isa_master, i_sbhe_n, i_local_hit, i_wide_enable;
  logic [3:0] cmd_n;
  logic [16:0] i_sa;
  logic [23:17] i_la;
  logic [15:0] i_sd, o_sd;
  logic [29:0] i_adr, o_adr;
  logic [31:0] i_local_data_bus, o_local_data_bus;
  logic [3:0] o_byte_lane_enables_n, wait_cyc;
  logic [2:0] i_target_claim_n, i_master_request_n, o_master_grant_n;
  logic [5:0] fixed;
  logic wide_ack_n;
  logic o_sd_oe, o_iochrdy_oe, o_memcs16_n_oe, o_adr_oe, o_address_strobe_n, o_mem_io, o_write_read;
  logic o_wide_transfer_request_n, o_local_data_bus_oe, i_target_ready_n, o_answer_oe, o_ready_return_n;
  int err_count, comparisons;
  // ==========================================================
  // design, target model and wire resolution
  idb_bridge i_dut (.i_core_clk, .i_nrst, .i_memr_n(cmd_n[3]), .i_memw_n(cmd_n[2]), .i_ior_n(cmd_n[1]),
    .i_iow_n(cmd_n[0]), .i_aen, .i_refresh_n, .i_isa_master, .i_sa, .i_la, .i_sbhe_n, .i_sd, .o_sd, .o_sd_oe,
    .o_iochrdy(fixed[5]), .o_iochrdy_oe, .o_memcs16_n(fixed[4]), .o_memcs16_n_oe, .i_adr, .o_adr, .o_adr_oe,
    .o_address_strobe_n, .o_byte_lane_enables_n, .o_mem_io, .o_write_read, .o_data_code(fixed[3]),
    .o_wide_transfer_request_n, .i_local_data_bus, .o_local_data_bus, .o_local_data_bus_oe, .i_target_ready_n,
    .i_burst_ready_n(1'h1), .i_size16_request_n(1'h1), .i_wide_transfer_ack_n(wide_ack_n),
    .o_burst_ready_n(fixed[2]), .o_size16_request_n(fixed[1]), .o_wide_transfer_ack_n(fixed[0]), .o_answer_oe,
    .o_ready_return_n, .i_target_claim_n,
    .i_master_request_n, .o_master_grant_n, .i_local_hit, .i_wide_enable);
  idb_tgt_model i_tgt (.i_core_clk, .i_nrst, .i_adr(o_adr), .i_adr_oe(o_adr_oe),
    .i_address_strobe_n(o_address_strobe_n), .i_write_read(o_write_read), .i_ready_return_n(o_ready_return_n),
    .i_wait(wait_cyc), .i_bridge_data(o_local_data_bus), .i_bridge_data_oe(o_local_data_bus_oe),
    .o_target_claim_n(i_target_claim_n), .o_target_ready_n(i_target_ready_n), .o_data_level(i_local_data_bus));
  // no master model: undriven address pins read back inverted rather than hold
  assign i_adr = o_adr_oe ? o_adr : ~o_adr;
  // clock
  initial
  begin
    i_core_clk = 1'h0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  // ==========================================================
  // shared tasks
  task automatic tick;
    @(posedge i_core_clk);
    #1;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // one isa command; cmd is one-hot memr, memw, ior, iow
  task automatic isa_cycle(input string nm, input logic [3:0] cmd, input logic [23:0] a, input logic aen_v,
    input logic ref_n, input logic hit, input logic claim);
    logic ads, wt, cs, rr, mio, wr, wide, sdv, live;
    logic [29:0] adr;
    logic [3:0] be;
    logic [31:0] ld;
    logic [15:0] sd;
    logic [29:0] up_adr;
    logic [3:0] up_be;
    {ads, wt, cs, rr, sdv} = 5'h00;
    live = claim && ref_n && !hit;
    i_sa = a[16:0];
    i_la = a[23:17];
    i_aen = aen_v;
    i_isa_master = !aen_v;
    i_refresh_n = ref_n;
    i_local_hit = hit;
    i_sd = 16'h3C96 ^ a[15:0];
    tick;
    cmd_n = ~cmd;
    repeat (40)
    begin
      tick;
      if (!o_address_strobe_n)
        {ads, mio, wr, adr, be, wide} = {1'h1, o_mem_io, o_write_read, o_adr, o_byte_lane_enables_n,
          o_wide_transfer_request_n};
      if (o_local_data_bus_oe)
        ld = o_local_data_bus;
      if (o_sd_oe)
        {sdv, sd} = {1'h1, o_sd};
      // data phase view of the address group, where wide lanes ride
      if (o_iochrdy_oe)
        {up_adr, up_be} = {o_adr, o_byte_lane_enables_n};
      wt |= o_iochrdy_oe;
      cs |= o_memcs16_n_oe;
      rr |= !o_ready_return_n;
      if (rr)
        cmd_n = 4'hF;
    end
    cmd_n = 4'hF;
    i_aen = 1'h0;
    i_isa_master = 1'h0;
    repeat (4) tick;
    check({nm, " strobe"}, ads, ref_n);
    check({nm, " wait"}, wt, live);
    check({nm, " cs16"}, cs, live);
    check({nm, " return"}, rr, live);
    if (ref_n)
    begin
      check({nm, " mio"}, mio, cmd[3] | cmd[2]);
      check({nm, " wr"}, wr, cmd[2] | cmd[0]);
      check({nm, " adr"}, adr, {8'h00, a[23:2]});
      check({nm, " be"}, be, a[1] ? {1'h0, a[0], 2'h3} : {2'h3, 1'h0, a[0]});
      check({nm, " wide"}, wide, !i_wide_enable);
    end
    if (live)
    begin
      check({nm, " upper adr"}, up_adr, (i_wide_enable && !wide_ack_n) ? 30'h0000_0000 : {8'h00, a[23:2]});
      check({nm, " upper be"}, up_be, (i_wide_enable && !wide_ack_n) ? 4'hF :
        (a[1] ? {1'h0, a[0], 2'h3} : {2'h3, 1'h0, a[0]}));
    end
    if (live && cmd[2])
      check({nm, " wdata"}, a[1] ? ld[31:16] : ld[15:0], i_sd);
    if (live && cmd[3])
      check({nm, " rdata"}, sd, a[1] ? 16'hA5C3 : 16'h5AF1);
    check({nm, " sd drive"}, sdv, live && cmd[3]);
    $display("done %s", nm);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_mem_writes;
    i_wide_enable = 1'h1;
    wide_ack_n = 1'h0;
    isa_cycle("dma write hi", 4'h4, 24'hC1_2346, 1'h1, 1'h1, 1'h0, 1'h1);
    wide_ack_n = 1'h1;
    i_wide_enable = 1'h0;
    wait_cyc = 4'hC;
    isa_cycle("master write lo", 4'h4, 24'hC0_0011, 1'h0, 1'h1, 1'h0, 1'h1);
  endtask
  task automatic t_mem_read;
    isa_cycle("dma read slow", 4'h8, 24'hC2_0100, 1'h1, 1'h1, 1'h0, 1'h1);
    wait_cyc = 4'h4;
    isa_cycle("dma read prompt", 4'h8, 24'hC2_0106, 1'h1, 1'h1, 1'h0, 1'h1);
  endtask
  task automatic t_io;
    isa_cycle("io read", 4'h2, 24'hC0_0300, 1'h0, 1'h1, 1'h0, 1'h1);
    isa_cycle("io write", 4'h1, 24'hC0_0302, 1'h1, 1'h1, 1'h0, 1'h1);
  endtask
  task automatic t_refused;
    isa_cycle("refresh", 4'h8, 24'hC0_0000, 1'h1, 1'h0, 1'h0, 1'h1);
    isa_cycle("unclaimed", 4'h4, 24'h10_2000, 1'h1, 1'h1, 1'h0, 1'h0);
    isa_cycle("local hit", 4'h8, 24'hC0_2000, 1'h1, 1'h1, 1'h1, 1'h1);
    i_local_hit = 1'h0;
  endtask
  task automatic t_local_master;
    logic ads;
    int n;
    ads = 1'h0;
    i_master_request_n = 3'h1;
    for (n = 0; n < 10 && o_master_grant_n !== 3'h5; n++)
      tick;
    check("grant", o_master_grant_n, 3'h5);
    check("adr released", o_adr_oe, 1'h0);
    check("answers driven", o_answer_oe, 1'h1);
    check("fixed levels", fixed, 6'h0F);
    i_aen = 1'h1;
    cmd_n = 4'hB;
    repeat (10)
    begin
      tick;
      ads |= !o_address_strobe_n;
    end
    check("no strobe while granted", ads, 1'h0);
    cmd_n = 4'hF;
    i_aen = 1'h0;
    i_master_request_n = 3'h7;
    repeat (4) tick;
    check("grant dropped", o_master_grant_n, 3'h7);
    $display("done local master");
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    {i_nrst, i_aen, i_refresh_n, i_isa_master, i_sbhe_n, i_local_hit, i_wide_enable} = 7'h10;
    {cmd_n, wait_cyc, i_master_request_n} = 11'h7A7;
    {i_sa, i_la, i_sd} = 40'h00_0000_0000;
    err_count = 0;
    comparisons = 0;
    wide_ack_n = 1'h1;
    repeat (16) @(posedge i_core_clk);
    #1;
    i_nrst = 1'h1;
    repeat (3) tick;
    t_mem_writes();
    t_mem_read();
    t_io();
    t_refused();
    t_local_master();
    report_and_stop();
  end
  // about 440 cycles expected; a hang ends the run as a mismatch
  initial
  begin
    #100000;
    err_count++;
    $display("watchdog expired");
    report_and_stop();
  end
endmodule
